// [src/fris_pkg.sv]
// Constants and types shared by the floppy rate, input and status block.
// Assumes an eight-bit I/O port space with ten decoded address bits.
package fris_pkg;
   localparam logic [9:0] ADDR_DSR = 10'h3f4;
   localparam logic [9:0] ADDR_DATA = 10'h3f5;
   localparam logic [9:0] ADDR_CFG = 10'h3f7;
   typedef enum logic [1:0] {
      MODE_NONE = 2'h0,
      MODE_COMPACT = 2'h1,
      MODE_ALT = 2'h2,
      MODE_BASE = 2'h3
   } fris_mode_e;
   localparam logic [1:0] RATE_500K = 2'h0;
   localparam logic [1:0] RATE_300K = 2'h1;
   localparam logic [1:0] RATE_250K = 2'h2;
   localparam logic [1:0] RATE_1M = 2'h3;
   localparam logic [1:0] RATE_RST = RATE_250K;
   localparam logic PRECOMP_RST = 1'b0;
   localparam logic DENS_RST = 1'b1;
   localparam int PRECOMP_BIT = 2;
   localparam int SWRST_BIT = 7;
   localparam logic [3:0] ALT_ONES = 4'hf;
   localparam logic [6:0] RECAL_STEPS = 7'h50;
   localparam logic [1:0] MISS_INDEX = 2'h2;
   localparam int BYTE1_EN = 7;
   localparam int BYTE1_CRC = 5;
   localparam int BYTE1_OR = 4;
   localparam int BYTE1_NOSEC = 2;
   localparam int BYTE1_WPROT = 1;
   localparam int BYTE1_MARK = 0;
   typedef enum logic [1:0] {
      RES_IDLE = 2'b00,
      RES_BYTE0 = 2'b01,
      RES_BYTE1 = 2'b11
   } fris_res_e;
endpackage

// [src/fris_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin inputs; output changes when stages two and three agree.
`timescale 1ns/1ns
module fris_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Pins in, filtered levels out
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   for (genvar i = 0; i < W; i++) begin : g_agree
      always_ff @(posedge clk_sys) begin
         if (!resetn) begin
            level_q[i] <= RST_VAL[i];
         end else if (s2_q[i] == s3_q[i]) begin
            level_q[i] <= s3_q[i];
         end
      end
   end
endmodule

// [src/fris_status.sv]
// Result status bytes zero and one, built from core events.
// Assumes event inputs other than recal_active, track_zero, write_active and id_search (levels) are one-cycle pulses on clk_sys.
`timescale 1ns/1ns
module fris_status
   import fris_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Command framing
   input wire logic clr,
   input wire logic cmd_end,
   input wire logic [1:0] term_code,
   input wire logic head_addr,
   input wire logic [1:0] unit_select,
   // Events
   input wire logic seek_done,
   input wire logic recal_active,
   input wire logic step_pulse,
   input wire logic track_zero,
   input wire logic rel_underflow,
   input wire logic end_cyl,
   input wire logic crc_err,
   input wire logic late,
   input wire logic no_data,
   input wire logic wp_rise,
   input wire logic write_active,
   input wire logic id_search,
   input wire logic index_fall,
   input wire logic data_miss,
   // Bytes
   output logic [7:0] stat0,
   output logic [7:0] stat1
);
   logic [1:0] code_q;
   logic hd_q;
   logic [1:0] us_q;
   logic seek_end_q;
   logic fault_q;
   logic [7:0] stat1_q;
   logic [7:0] set1;
   logic [6:0] step_q;
   logic [1:0] idx_q;
   logic fault_set;
   logic mark_lost;

   // Missing mark is flagged on the second index while still hunting
   assign mark_lost = index_fall & id_search & (idx_q == MISS_INDEX - 2'h1);

   always_comb begin
      set1 = 8'h00;
      set1[BYTE1_EN] = end_cyl;
      set1[BYTE1_CRC] = crc_err;
      set1[BYTE1_OR] = late;
      set1[BYTE1_NOSEC] = no_data;
      set1[BYTE1_WPROT] = wp_rise & write_active;
      set1[BYTE1_MARK] = data_miss | mark_lost;
   end

   assign fault_set = (recal_active & step_pulse & ~track_zero
                       & (step_q == RECAL_STEPS - 7'h01)) | rel_underflow;

   always_ff @(posedge clk_sys) begin
      if (!resetn || !recal_active) begin
         step_q <= 7'h00;
      end else if (step_pulse && step_q != RECAL_STEPS) begin
         step_q <= step_q + 7'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || !id_search) begin
         idx_q <= 2'h0;
      end else if (index_fall && idx_q != MISS_INDEX) begin
         idx_q <= idx_q + 2'h1;
      end
   end

   // Set wins over the clear of a new command
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stat1_q <= 8'h00;
         seek_end_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         stat1_q <= (clr ? 8'h00 : stat1_q) | set1;
         seek_end_q <= (clr ? 1'b0 : seek_end_q) | seek_done;
         fault_q <= (clr ? 1'b0 : fault_q) | fault_set;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         code_q <= 2'h0;
         hd_q <= 1'b0;
         us_q <= 2'h0;
      end else if (cmd_end) begin
         code_q <= term_code;
         hd_q <= head_addr;
         us_q <= unit_select;
      end
   end

   assign stat0 = {code_q, seek_end_q, fault_q, 1'b0, hd_q, us_q};
   assign stat1 = stat1_q;

   property p_code;
      @(posedge clk_sys) disable iff (!resetn)
      cmd_end |=> stat0[7:6] == $past(term_code);
   endproperty
   a_code: assert property (p_code) else $error("code not latched");

   property p_fault;
      @(posedge clk_sys) disable iff (!resetn)
      recal_active && step_pulse && !track_zero && step_q == 7'h4f |=> stat0[4];
   endproperty
   a_fault: assert property (p_fault) else $error("fault missed");

   property p_st_zero;
      @(posedge clk_sys) disable iff (!resetn)
      !stat0[3] && !stat1[6] && !stat1[3];
   endproperty
   a_st_zero: assert property (p_st_zero) else $error("unused bit set");

   property p_wprot;
      @(posedge clk_sys) disable iff (!resetn)
      wp_rise && write_active |=> stat1[BYTE1_WPROT] [*2];
   endproperty
   a_wprot: assert property (p_wprot) else $error("protect lost");

   c_fault: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(fault_q));
endmodule

// [src/fris_top.sv]
// Host-visible rate, input and result status registers of a floppy core.
// Assumes a synchronous I/O strobe bus and event pulses from the core.
`timescale 1ns/1ns
module fris_top
   import fris_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // I/O port bus
   input wire logic [9:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // Configuration
   input wire fris_pkg::fris_mode_e iface_mode,
   input wire logic dma_gate,
   input wire logic force_change_en,
   input wire logic force_change_val,
   input wire logic sw_reset_drive,
   // Drive cable
   input wire logic media_change_pin_n,
   input wire logic track_zero_pin,
   input wire logic write_protect_pin,
   input wire logic rotation_index_pin_n,
   output logic density_select_pin,
   // Core command framing
   input wire logic cmd_start,
   input wire logic cmd_end,
   input wire logic [1:0] termination_code,
   input wire logic head_addr,
   input wire logic [1:0] unit_select,
   input wire logic result_start,
   // Core events
   input wire logic seek_done,
   input wire logic recal_active,
   input wire logic step_pulse,
   input wire logic rel_seek_underflow,
   input wire logic end_cyl,
   input wire logic crc_fault,
   input wire logic service_late,
   input wire logic sector_missing,
   input wire logic write_cmd_active,
   input wire logic id_search_active,
   input wire logic data_mark_missing,
   // Control out
   output logic [1:0] rate_select,
   output logic precomp_disable,
   output logic result_active,
   output logic sw_reset_pulse
);
   import fris_pkg::*;

   function automatic logic hit(input logic [9:0] a, input logic [9:0] t);
      hit = (a == t);
   endfunction

   function automatic logic is_compact(input fris_mode_e m);
      is_compact = (m == MODE_COMPACT);
   endfunction

   function automatic logic is_alt(input fris_mode_e m);
      is_alt = (m == MODE_ALT);
   endfunction

   logic [1:0] rate_q;
   logic [1:0] rate_d;
   logic prec_q;
   logic prec_d;
   logic dens_q;
   logic dens_live_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic swrst_q;
   fris_res_e res_q;
   fris_res_e res_d;
   logic [3:0] pins_s;
   logic [3:0] pins_prev_q;
   logic chg_s;
   logic track0_s;
   logic wp_s;
   logic idx_s;
   logic wp_rise;
   logic idx_fall;
   logic cfg_wr;
   logic dsr_wr;
   logic rate_wr;
   logic soft_rst;
   logic data_rd;
   logic chg_bit;
   logic hi_dens;
   logic [7:0] stat0;
   logic [7:0] stat1;

   // Cable pins are asynchronous to clk_sys
   fris_sync #(
      .W(4),
      .RST_VAL(4'b1001)
   ) u_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_in({media_change_pin_n, track_zero_pin, write_protect_pin, rotation_index_pin_n}),
      .level_q(pins_s)
   );

   assign chg_s = pins_s[3];
   assign track0_s = pins_s[2];
   assign wp_s = pins_s[1];
   assign idx_s = pins_s[0];

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pins_prev_q <= 4'b1001;
      end else begin
         pins_prev_q <= pins_s;
      end
   end

   assign wp_rise = wp_s & ~pins_prev_q[1];
   assign idx_fall = ~idx_s & pins_prev_q[0];

   // Decodes
   assign cfg_wr = io_wr & hit(io_addr, ADDR_CFG);
   assign dsr_wr = io_wr & hit(io_addr, ADDR_DSR);
   assign rate_wr = cfg_wr | dsr_wr;
   assign soft_rst = sw_reset_drive | (dsr_wr & io_wdata[SWRST_BIT]);
   assign data_rd = io_rd & hit(io_addr, ADDR_DATA);
   assign chg_bit = force_change_en ? force_change_val : ~chg_s;
   assign hi_dens = (rate_q == RATE_500K) | (rate_q == RATE_1M);

   // Rate select; a soft reset does not reach it
   always_comb begin
      rate_d = rate_q;
      if (rate_wr) begin
         rate_d = io_wdata[1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rate_q <= RATE_RST;
      end else begin
         rate_q <= rate_d;
      end
   end

   // Precomp disable is stored only in compact mode; it drives precomp_disable and the compact view
   always_comb begin
      prec_d = prec_q;
      if (cfg_wr && is_compact(iface_mode)) begin
         prec_d = io_wdata[PRECOMP_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prec_q <= PRECOMP_RST;
      end else begin
         prec_q <= prec_d;
      end
   end

   // Density stays high until the host first sets a rate
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         dens_live_q <= 1'b0;
      end else if (rate_wr) begin
         dens_live_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         dens_q <= DENS_RST;
      end else if (dens_live_q) begin
         dens_q <= hi_dens ^ (iface_mode == MODE_ALT || iface_mode == MODE_COMPACT);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         swrst_q <= 1'b0;
      end else begin
         swrst_q <= soft_rst;
      end
   end

   // Result phase read-out of the two status bytes
   always_comb begin
      res_d = res_q;
      unique case (res_q)
         RES_IDLE: begin
            if (result_start) begin
               res_d = RES_BYTE0;
            end
         end
         RES_BYTE0: begin
            if (data_rd) begin
               res_d = RES_BYTE1;
            end
         end
         RES_BYTE1: begin
            if (data_rd) begin
               res_d = RES_IDLE;
            end
         end
         default: begin
            res_d = RES_IDLE;
         end
      endcase
      if (soft_rst) begin
         res_d = RES_IDLE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         res_q <= RES_IDLE;
      end else begin
         res_q <= res_d;
      end
   end

   // Read views depend on the mode at the time of each access
   always_comb begin
      rdata_d = 8'h00;
      if (hit(io_addr, ADDR_CFG)) begin
         if (is_compact(iface_mode)) begin
            rdata_d = {chg_bit, 3'h0, dma_gate, prec_q, rate_q};
         end else if (is_alt(iface_mode)) begin
            rdata_d = {chg_bit, ALT_ONES, rate_q, ~hi_dens};
         end else begin
            rdata_d = {chg_bit, 7'h00};
         end
      end else if (hit(io_addr, ADDR_DATA)) begin
         if (res_q == RES_BYTE0) begin
            rdata_d = stat0;
         end else if (res_q == RES_BYTE1) begin
            rdata_d = stat1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else if (io_rd) begin
         rdata_q <= rdata_d;
      end
   end

   fris_status u_status (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clr(cmd_start | soft_rst),
      .cmd_end(cmd_end),
      .term_code(termination_code),
      .head_addr(head_addr),
      .unit_select(unit_select),
      .seek_done(seek_done),
      .recal_active(recal_active),
      .step_pulse(step_pulse),
      .track_zero(track0_s),
      .rel_underflow(rel_seek_underflow),
      .end_cyl(end_cyl),
      .crc_err(crc_fault),
      .late(service_late),
      .no_data(sector_missing),
      .wp_rise(wp_rise),
      .write_active(write_cmd_active),
      .id_search(id_search_active),
      .index_fall(idx_fall),
      .data_miss(data_mark_missing),
      .stat0(stat0),
      .stat1(stat1)
   );

   assign io_rdata = rdata_q;
   assign rate_select = rate_q;
   assign precomp_disable = prec_q;
   assign density_select_pin = dens_q;
   assign result_active = res_q[0];
   assign sw_reset_pulse = swrst_q;

   property p_rate_rst;
      @(posedge clk_sys) disable iff (!resetn)
      $rose(resetn) |-> rate_q == RATE_250K && prec_q == 1'b0;
   endproperty
   a_rate_rst: assert property (p_rate_rst) else $error("bad reset rate");

   property p_rate_soft;
      @(posedge clk_sys) disable iff (!resetn)
      sw_reset_drive && !rate_wr |=> $stable(rate_q) && $stable(prec_q);
   endproperty
   a_rate_soft: assert property (p_rate_soft) else $error("soft reset hit rate");

   property p_cfg_wr;
      @(posedge clk_sys) disable iff (!resetn)
      cfg_wr |=> rate_select == $past(io_wdata[1:0]);
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("rate not loaded");

   property p_alt_view;
      @(posedge clk_sys) disable iff (!resetn)
      io_rd && hit(io_addr, ADDR_CFG) && iface_mode == MODE_ALT
      |=> io_rdata[6:3] == 4'hf && io_rdata[2:1] == $past(rate_select);
   endproperty
   a_alt_view: assert property (p_alt_view) else $error("alt view wrong");

   property p_alt_dens;
      @(posedge clk_sys) disable iff (!resetn)
      io_rd && hit(io_addr, ADDR_CFG) && iface_mode == MODE_ALT
      |=> io_rdata[0] == ($past(rate_select) == RATE_300K || $past(rate_select) == RATE_250K);
   endproperty
   a_alt_dens: assert property (p_alt_dens) else $error("alt bit 0 wrong");

   property p_cmp_view;
      @(posedge clk_sys) disable iff (!resetn)
      io_rd && hit(io_addr, ADDR_CFG) && iface_mode == MODE_COMPACT
      |=> io_rdata[6:4] == 3'h0 && io_rdata[1:0] == $past(rate_select);
   endproperty
   a_cmp_view: assert property (p_cmp_view) else $error("compact view wrong");

   property p_cmp_prec;
      @(posedge clk_sys) disable iff (!resetn)
      io_rd && hit(io_addr, ADDR_CFG) && iface_mode == MODE_COMPACT
      |=> io_rdata[2] == $past(precomp_disable) && io_rdata[3] == $past(dma_gate);
   endproperty
   a_cmp_prec: assert property (p_cmp_prec) else $error("mirror bits wrong");

   property p_chg;
      @(posedge clk_sys) disable iff (!resetn)
      io_rd && hit(io_addr, ADDR_CFG)
      |=> io_rdata[7] == $past(force_change_en ? force_change_val : ~chg_s);
   endproperty
   a_chg: assert property (p_chg) else $error("change bit wrong");

   property p_prec_keep;
      @(posedge clk_sys) disable iff (!resetn)
      cfg_wr && !is_compact(iface_mode) |=> $stable(precomp_disable);
   endproperty
   a_prec_keep: assert property (p_prec_keep) else $error("precomp changed");

   property p_dens_rst;
      @(posedge clk_sys) disable iff (!resetn)
      $rose(resetn) |-> density_select_pin ##1 density_select_pin;
   endproperty
   a_dens_rst: assert property (p_dens_rst) else $error("density low at reset");

   property p_result;
      @(posedge clk_sys) disable iff (!resetn)
      res_q == RES_BYTE0 && data_rd && !soft_rst |=> io_rdata == $past(stat0) && res_q == RES_BYTE1;
   endproperty
   a_result: assert property (p_result) else $error("byte zero not given");

   c_cmp_read: cover property (@(posedge clk_sys) disable iff (!resetn)
      io_rd && hit(io_addr, ADDR_CFG) && iface_mode == MODE_COMPACT);
   c_result: cover property (@(posedge clk_sys) disable iff (!resetn)
      res_q == RES_BYTE1 && data_rd);
   c_soft: cover property (@(posedge clk_sys) disable iff (!resetn)
      soft_rst && dens_live_q);
endmodule

// [testbench/fris_drive_model.sv]
// Drive cable model: disk-change, track zero, write protect and index pins.
// Assumes the bench sets its controls at the falling edge; index idles high when stopped.
`timescale 1ns/1ns
module fris_drive_model (
   // Clock
   input wire logic clk_sys,
   // Controls from the bench
   input wire logic disk_changed,
   input wire logic protect,
   input wire logic at_track0,
   input wire logic spin,
   // Cable pins
   output logic media_change_pin_n,
   output logic track_zero_pin,
   output logic write_protect_pin,
   output logic rotation_index_pin_n
);
   logic [3:0] rev_q;
   assign media_change_pin_n = ~disk_changed;
   assign track_zero_pin = at_track0;
   assign write_protect_pin = protect;
   // Index low two cycles per 16-cycle turn; a stopped drive gives no edges at all
   always_ff @(posedge clk_sys) begin
      rev_q <= spin ? rev_q + 4'h1 : 4'h0;
   end
   assign rotation_index_pin_n = ~(spin && rev_q >= 4'he);
endmodule

// [testbench/fris_top_tb.sv]
// Self-checking bench for the rate, input view and result status block.
// Assumes the drive model owns the cable pins; every other input is driven here.
`timescale 1ns/1ns
module fris_top_tb;
   import fris_pkg::*;
   typedef struct {
      logic [1:0] mode;
      logic [7:0] wdata;
      logic dma, fen, fval, chg;
      logic [7:0] view;
      logic [1:0] rate;
   } fris_row_s;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [9:0] io_addr = 10'h000;
   logic io_rd = 1'b0, io_wr = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata, rd;
   fris_mode_e iface_mode = MODE_COMPACT;
   logic dma_gate = 1'b0, force_change_en = 1'b0, force_change_val = 1'b0, sw_reset_drive = 1'b0;
   logic disk_changed = 1'b0, protect = 1'b0, at_track0 = 1'b0, spin = 1'b0;
   logic media_change_pin_n, track_zero_pin, write_protect_pin, rotation_index_pin_n;
   logic density_select_pin, precomp_disable, result_active, sw_reset_pulse, dens;
   logic [1:0] rate_select;
   logic cmd_start = 1'b0, cmd_end = 1'b0, result_start = 1'b0, head_addr = 1'b0;
   logic [1:0] termination_code = 2'h0, unit_select = 2'h0;
   logic seek_done = 1'b0, recal_active = 1'b0, step_pulse = 1'b0, rel_seek_underflow = 1'b0;
   logic end_cyl = 1'b0, crc_fault = 1'b0, service_late = 1'b0, sector_missing = 1'b0;
   logic write_cmd_active = 1'b0, id_search_active = 1'b0, data_mark_missing = 1'b0;
   int failures = 0, cmp_count = 0;
   // Reserved control bits are always written as zero
   fris_row_s rows [8] = '{
      '{2'h2, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h78, 2'h0},
      '{2'h2, 8'h01, 1'b0, 1'b0, 1'b0, 1'b1, 8'hfb, 2'h1},
      '{2'h2, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0, 8'h7d, 2'h2},
      '{2'h2, 8'h03, 1'b0, 1'b1, 1'b1, 1'b0, 8'hfe, 2'h3},
      '{2'h3, 8'h02, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 2'h2},
      '{2'h0, 8'h03, 1'b0, 1'b0, 1'b0, 1'b1, 8'h80, 2'h3},
      '{2'h1, 8'h07, 1'b1, 1'b0, 1'b0, 1'b0, 8'h0f, 2'h3},
      '{2'h1, 8'h01, 1'b0, 1'b1, 1'b1, 1'b1, 8'h81, 2'h1}};
   // Event masks in order seek, underflow, end, crc, late, missing, mark
   logic [6:0] ev [4] = '{7'h00, 7'h50, 7'h2a, 7'h05};
   logic [7:0] ex0 [4] = '{8'h03, 8'h66, 8'h91, 8'hc4};
   logic [7:0] ex1 [4] = '{8'h00, 8'h80, 8'h24, 8'h11};

   fris_top dut (.*);
   fris_drive_model drive (.*);

   always #25 clk_sys = ~clk_sys;

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic io_write(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk_sys);
      io_wr = 1'b0;
   endtask

   task automatic io_read(input logic [9:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk_sys);
      io_rd = 1'b0;
      d = io_rdata;
   endtask

   task automatic begin_cmd();
      @(negedge clk_sys);
      cmd_start = 1'b1;
      @(negedge clk_sys);
      cmd_start = 1'b0;
   endtask

   task automatic fire(input logic [6:0] m);
      @(negedge clk_sys);
      {seek_done, rel_seek_underflow, end_cyl, crc_fault, service_late, sector_missing,
         data_mark_missing} = m;
      @(negedge clk_sys);
      {seek_done, rel_seek_underflow, end_cyl, crc_fault, service_late, sector_missing,
         data_mark_missing} = 7'h00;
   endtask

   task automatic end_cmd(input logic [1:0] c, input logic h, input logic [1:0] u,
         input logic [7:0] e0, input logic [7:0] e1);
      logic [7:0] d;
      int n;
      @(negedge clk_sys);
      termination_code = c;
      head_addr = h;
      unit_select = u;
      cmd_end = 1'b1;
      @(negedge clk_sys);
      cmd_end = 1'b0;
      result_start = 1'b1;
      @(negedge clk_sys);
      result_start = 1'b0;
      n = 0;
      while (result_active !== 1'b1 && n < 4) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 4) begin
         failures++;
         finish_test();
      end
      io_read(ADDR_DATA, d);
      check8("status byte 0", e0, d);
      io_read(ADDR_DATA, d);
      check8("status byte 1", e1, d);
      check8("result active", 8'h00, {7'h00, result_active});
   endtask

   initial begin
      repeat (4) @(negedge clk_sys);
      resetn = 1'b1;
      check8("rate after reset", 8'h02, {6'h00, rate_select});
      check8("density after reset", 8'h01, {7'h00, density_select_pin});
      io_read(ADDR_CFG, rd);
      check8("compact view reset", 8'h02, rd);
      iface_mode = MODE_ALT;
      io_read(ADDR_CFG, rd);
      check8("alt view reset", 8'h7d, rd);
      foreach (rows[i]) begin
         iface_mode = fris_mode_e'(rows[i].mode);
         dma_gate = rows[i].dma;
         force_change_en = rows[i].fen;
         force_change_val = rows[i].fval;
         disk_changed = rows[i].chg;
         io_write(ADDR_CFG, rows[i].wdata);
         repeat (6) @(negedge clk_sys);
         io_read(ADDR_CFG, rd);
         check8("input view", rows[i].view, rd);
         check8("rate", {6'h00, rows[i].rate}, {6'h00, rate_select});
      end
      // Soft resets from both sources must leave rate, precomp and density alone
      force_change_en = 1'b0;
      disk_changed = 1'b0;
      io_write(ADDR_CFG, 8'h07);
      // Density follows a new rate one cycle late, so let it settle first
      @(negedge clk_sys);
      dens = density_select_pin;
      sw_reset_drive = 1'b1;
      @(negedge clk_sys);
      check8("soft reset pulse", 8'h01, {7'h00, sw_reset_pulse});
      sw_reset_drive = 1'b0;
      io_write(ADDR_DSR, 8'h83);
      check8("soft reset pulse", 8'h01, {7'h00, sw_reset_pulse});
      repeat (6) @(negedge clk_sys);
      check8("rate after soft reset", 8'h03, {6'h00, rate_select});
      check8("precomp after soft reset", 8'h01, {7'h00, precomp_disable});
      check8("density after soft reset", {7'h00, dens}, {7'h00, density_select_pin});
      io_read(ADDR_CFG, rd);
      check8("compact view precomp", 8'h07, rd);
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      check8("rate after hard reset", 8'h02, {6'h00, rate_select});
      check8("precomp after hard reset", 8'h00, {7'h00, precomp_disable});
      check8("density after hard reset", 8'h01, {7'h00, density_select_pin});
      repeat (6) @(negedge clk_sys);
      for (int c = 0; c < 4; c++) begin
         begin_cmd();
         fire(ev[c]);
         end_cmd(2'(c), c[0], ~2'(c), ex0[c], ex1[c]);
      end
      io_read(ADDR_DATA, rd);
      check8("data port idle", 8'h00, rd);
      // One step short, or track zero reached in time, must not flag the fault
      for (int n = 79; n <= 81; n++) begin
         begin_cmd();
         recal_active = 1'b1;
         at_track0 = (n == 81);
         repeat ((n == 81) ? 80 : n) begin
            @(negedge clk_sys);
            step_pulse = 1'b1;
            @(negedge clk_sys);
            step_pulse = 1'b0;
         end
         recal_active = 1'b0;
         at_track0 = 1'b0;
         end_cmd(2'h1, 1'b0, 2'h0, (n == 80) ? 8'h50 : 8'h40, 8'h00);
      end
      begin_cmd();
      write_cmd_active = 1'b1;
      id_search_active = 1'b1;
      spin = 1'b1;
      repeat (6) @(negedge clk_sys);
      protect = 1'b1;
      repeat (40) @(negedge clk_sys);
      write_cmd_active = 1'b0;
      id_search_active = 1'b0;
      spin = 1'b0;
      protect = 1'b0;
      end_cmd(2'h1, 1'b0, 2'h0, 8'h40, 8'h03);
      finish_test();
   end
endmodule
